// File: design/ssr_pkg.sv
package ssr_pkg;
  // number of shift stages and parallel outputs
  localparam int unsigned STAGES      = 8;
  // stage indices that feed the two cascade outputs
  localparam int unsigned EARLY_TAP   = 6;
  localparam int unsigned LATE_TAP    = 7;
  // pin inputs pass this many synchroniser flops
  localparam int unsigned SYNC_DEPTH  = 3;
  // power-up value of every register, the part itself has no reset
  localparam logic        RESET_BIT   = 1'h0;
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
endpackage

// File: design/ssr_shift_store.sv
`timescale 1ns/100ps
// Overview of operation
// [R1] eight stages, stage 0 takes serial input
// [R2] stages advance only on shift clock rise
// [R3] early output takes stage 6 on rise
// [R4] late output takes stage 7 on fall
// [R5] cascade from early or late per edge speed
// [R6] strobe high: storage follows stages, low: holds
// [R7] enable high drives storage bits onto outputs
// [R8] enable low floats all parallel outputs
// [R9] enable never changes stages or storage
// [R10] separate controls for shift and storage
// [R11] serial outputs always driven and updating
module ssr_shift_store #(
  parameter int unsigned STAGES = ssr_pkg::STAGES
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              shift_clock,
  input  wire logic              serial_in,
  input  wire logic              storage_load,
  input  wire logic              output_enable,
  output logic [STAGES-1:0]      parallel_out,
  output logic [STAGES-1:0]      parallel_out_oe,
  output logic                   serial_out_early,
  output logic                   serial_out_late
);
  // taps and reset words are fixed for eight stages, so any other depth is
  // refused while the design is built rather than misbehaving later
  if (STAGES != ssr_pkg::STAGES) begin
    $error("ssr_shift_store: only eight stages are supported");
  end
  // the early tap must sit one stage ahead of the last stage
  if (ssr_pkg::EARLY_TAP + 1 != ssr_pkg::LATE_TAP) begin
    $error("ssr_shift_store: early tap must precede the late tap");
  end
  // the late tap is the last stage, the one a chain receives
  if (ssr_pkg::LATE_TAP != STAGES - 1) begin
    $error("ssr_shift_store: late tap must be the last stage");
  end
  // the reset word must cover every stage exactly
  if ($bits(ssr_pkg::RESET_BYTE) != STAGES) begin
    $error("ssr_shift_store: reset word width must match the stages");
  end
  // the synchroniser is built with three flops and no more
  if (ssr_pkg::SYNC_DEPTH != 3) begin
    $error("ssr_shift_store: synchronisers are three flops deep");
  end

  // every pin reaches the logic five edges after it changes: three filter
  // flops, the agreement flop and the output flop; the controller must keep
  // each shift clock level for at least two clk_sys samples or the edge is lost

  logic clk_s;
  logic din_s;
  logic str_s;
  logic oe_s;

  // every pin is brought into clk_sys through its own synchroniser
  ssr_sync u_sync_clk (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (shift_clock),
    .level_q (clk_s)
  );
  // serial data passes the same filter, so it stays aligned with the clock
  ssr_sync u_sync_din (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (serial_in),
    .level_q (din_s)
  );
  // storage strobe, a level that opens the storage register
  ssr_sync u_sync_str (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (storage_load),
    .level_q (str_s)
  );
  // output enable, touches only the pin drivers
  ssr_sync u_sync_oe (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (output_enable),
    .level_q (oe_s)
  );

  // previous level of the filtered shift clock, the base of edge detection
  logic              clk_prev_q;
  logic              clk_prev_d;
  logic              rise;
  logic              fall;

  // rise and fall come from one stored level, so they never meet in a cycle;
  // a pulse shorter than the filter window on either level is lost, which
  // is the price of filtering an asynchronous clock pin
  always_comb begin
    clk_prev_d = clk_s;
    rise       = clk_s & ~clk_prev_q;                       // [R2]
    fall       = ~clk_s & clk_prev_q;                       // [R4]
  end

  // clears to the idle low level of the pin, so no false rise follows reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clk_prev_q <= ssr_pkg::RESET_BIT;
    end else begin
      clk_prev_q <= clk_prev_d;
    end
  end

  // the eight shift stages, stage 0 nearest the serial input
  logic [STAGES-1:0] stage_q;
  logic [STAGES-1:0] stage_d;

  // stages move one place per detected rise; data passes the same filter as
  // the clock, so it keeps the set-up margin it had at the pin
  always_comb begin
    stage_d = stage_q;
    if (rise) begin                                         // [R2] [R10]
      stage_d = {stage_q[STAGES-2:0], din_s};               // [R1]
    end
  end

  // a falling edge never reaches this register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage_q <= ssr_pkg::RESET_BYTE;
    end else begin
      stage_q <= stage_d;
    end
  end

  // cascade outputs and the stage values they are taken from
  logic              stage6_before_rise;
  logic              stage7_before_fall;
  logic              early_q;
  logic              early_d;
  logic              late_q;
  logic              late_d;

  // taps read the stages as they stand before the edge is applied
  assign stage6_before_rise = stage_q[ssr_pkg::EARLY_TAP];
  assign stage7_before_fall = stage_q[ssr_pkg::LATE_TAP];

  // neither the strobe nor the enable is looked at here, so a chain keeps
  // moving while the parallel pins float; the late output lags by half a
  // shift period, which is what makes it safe with slow edges
  always_comb begin
    early_d = early_q;
    late_d  = late_q;
    if (rise) begin
      early_d = stage6_before_rise;                         // [R3] [R11]
    end
    if (fall) begin
      late_d = stage7_before_fall;                          // [R4] [R11]
    end
  end

  // both outputs are flops with no enable in their path, so they are
  // driven at all times
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      early_q <= ssr_pkg::RESET_BIT;
      late_q  <= ssr_pkg::RESET_BIT;
    end else begin
      early_q <= early_d;
      late_q  <= late_d;
    end
  end

  // storage register behind the parallel pins
  logic [STAGES-1:0] store_q;
  logic [STAGES-1:0] store_d;

  // transparent while the strobe is high: it takes the value just shifted in
  // the same cycle, so the pins track each shift; the enable plays no part,
  // so floating the pins can never disturb what is stored
  always_comb begin
    store_d = store_q;
    if (str_s) begin
      store_d = stage_d;                                    // [R6] [R9] [R10]
    end
  end

  // holds its contents whenever the strobe is low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      store_q <= ssr_pkg::RESET_BYTE;
    end else begin
      store_q <= store_d;
    end
  end

  // registered pin drivers, data and per-bit enable
  logic [STAGES-1:0] pout_q;
  logic [STAGES-1:0] pout_d;
  logic [STAGES-1:0] poe_q;
  logic [STAGES-1:0] poe_d;

  // data is taken from the storage next value so a load reaches the pins
  // with no extra cycle; the enable only decides whether the pins drive
  always_comb begin
    pout_d = store_d;                                       // [R7]
    poe_d  = {STAGES{oe_s}};                                // [R7] [R8]
  end

  // after reset the pins float until the enable has passed its filter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pout_q <= ssr_pkg::RESET_BYTE;
      poe_q  <= ssr_pkg::RESET_BYTE;
    end else begin
      pout_q <= pout_d;
      poe_q  <= poe_d;
    end
  end

  // pins are floated by the enable only; data keeps moving underneath
  assign parallel_out     = pout_q;
  assign parallel_out_oe  = poe_q;                          // [R8]
  assign serial_out_early = early_q;
  assign serial_out_late  = late_q;
endmodule

// File: design/ssr_sync.sv
`timescale 1ns/100ps
// three-flop synchroniser; a change is accepted once flops two and three agree
module ssr_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      level_q
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic       level_d;

  // flop 0 is read only by flop 1
  always_comb begin
    sync_d  = {sync_q[1:0], pin_in};
    level_d = (sync_q[2] == sync_q[1]) ? sync_q[2] : level_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_q  <= {3{ssr_pkg::RESET_BIT}};
      level_q <= ssr_pkg::RESET_BIT;
    end else begin
      sync_q  <= sync_d;
      level_q <= level_d;
    end
  end
endmodule

// File: test/ssr_ctrl_model.sv
`timescale 1ns/100ps
// controller at the serial pins; slow 8-cycle half periods suit the synchronisers
module ssr_ctrl_model (
  input  wire logic       clk_sys,
  input  wire logic       serial_out_late,
  output logic            shift_clock,
  output logic            serial_in,
  output logic [7:0]      cascade_byte
);
  initial shift_clock = 1'h0;
  initial serial_in = 1'h0;
  initial cascade_byte = 8'h00;
  // msb first, data steady long before each rise, clock idles low
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      serial_in = b[i];
      repeat (8) @(negedge clk_sys);
      // edges here are slow, so a chained device is fed from the late output
      cascade_byte = {cascade_byte[6:0], serial_out_late};
      shift_clock = 1'h1;
      repeat (8) @(negedge clk_sys);
      shift_clock = 1'h0;
    end
    serial_in = ~serial_in; // released line shows no stale bit
  endtask
endmodule

// File: test/ssr_monitor.sv
`timescale 1ns/100ps
// windows of seven samples cover the five-edge pin latency of the block
module ssr_monitor (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       shift_clock,
  input wire logic       storage_load,
  input wire logic       output_enable,
  input wire logic [7:0] parallel_out,
  input wire logic [7:0] parallel_out_oe,
  input wire logic       serial_out_early,
  input wire logic       serial_out_late
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_oe_all_same: assert property (
    parallel_out_oe == 8'h00 || parallel_out_oe == 8'hff)
    else $error("oe bits differ");
  a_oe_drives: assert property (
    output_enable[*6] ##1 output_enable |-> parallel_out_oe == 8'hff)
    else $error("outputs not driven");
  a_oe_floats: assert property (
    !output_enable[*6] ##1 !output_enable |-> parallel_out_oe == 8'h00)
    else $error("outputs not floated");
  a_store_holds: assert property (
    !storage_load[*6] ##1 !storage_load |-> $stable(parallel_out))
    else $error("storage moved");
  a_low_no_shift: assert property (
    !shift_clock[*6] ##1 !shift_clock |-> $stable(serial_out_early))
    else $error("early output moved with clock low");
  a_low_par_still: assert property (
    (!shift_clock && storage_load)[*6] ##1 (!shift_clock && storage_load)
      |-> $stable(parallel_out))
    else $error("parallel outputs moved with clock low");
  a_late_holds: assert property (
    shift_clock[*6] ##1 shift_clock |-> $stable(serial_out_late))
    else $error("late moved on high");
  a_late_low: assert property (
    !shift_clock[*6] ##1 !shift_clock |-> $stable(serial_out_late))
    else $error("late moved on low");
  a_shift_one: assert property (
    storage_load[*6] ##1 $changed(parallel_out)
      |-> parallel_out[7:1] == $past(parallel_out[6:0]))
    else $error("not a one-stage shift");
  c_shift: cover property ($changed(parallel_out));
  c_float: cover property ($fell(parallel_out_oe[0]));
  c_late: cover property ($changed(serial_out_late));
  c_early: cover property ($changed(serial_out_early));
endmodule

// File: test/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic       clk_sys = 1'h0;
  logic       rst_n = 1'h0;
  logic       storage_load = 1'h1;
  logic       output_enable = 1'h1;
  logic       shift_clock, serial_in, serial_out_early, serial_out_late;
  logic [7:0] parallel_out, parallel_out_oe, cascade_byte;
  int         err_total = 0;
  int         checks = 0;
  always #5 clk_sys = ~clk_sys;
  ssr_ctrl_model u_ctrl (.clk_sys, .shift_clock, .serial_in, .serial_out_late, .cascade_byte);
  ssr_shift_store u_dut (.clk_sys, .rst_n, .shift_clock, .serial_in, .storage_load,
    .output_enable, .parallel_out, .parallel_out_oe, .serial_out_early, .serial_out_late);
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // transparent storage: first bit ends in stage 7
  task automatic run_shift_show();
    u_ctrl.send_byte(8'ha5);
    repeat (8) @(negedge clk_sys);
    check("parallel_out", parallel_out, 8'ha5);
    check("oe", parallel_out_oe, 8'hff);
    check("early", {7'h00, serial_out_early}, 8'h01);
    check("late", {7'h00, serial_out_late}, 8'h01);
  endtask
  // strobe low holds, enable low floats, serial outputs keep moving
  task automatic run_hold_float();
    storage_load = 1'h0;
    output_enable = 1'h0;
    u_ctrl.send_byte(8'h3c);
    repeat (8) @(negedge clk_sys);
    check("held", parallel_out, 8'ha5);
    check("oe off", parallel_out_oe, 8'h00);
    check("early off", {7'h00, serial_out_early}, 8'h00);
    check("late off", {7'h00, serial_out_late}, 8'h00);
    check("cascade", cascade_byte, 8'ha5);
    storage_load = 1'h1;
    output_enable = 1'h1;
    repeat (8) @(negedge clk_sys);
    check("loaded", parallel_out, 8'h3c);
    output_enable = 1'h0;
    repeat (8) @(negedge clk_sys);
    check("oe only", parallel_out, 8'h3c);
    check("oe only off", parallel_out_oe, 8'h00);
    output_enable = 1'h1;
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1'h1;
    repeat (4) @(negedge clk_sys);
    check("oe rst", parallel_out_oe, 8'h00);
    run_shift_show();
    run_hold_float();
    test_done();
  end
  // hang guard
  initial begin
    #200000;
    err_total++;
    test_done();
  end
endmodule
bind ssr_shift_store ssr_monitor u_mon (.clk_sys, .rst_n, .shift_clock, .storage_load,
  .output_enable, .parallel_out, .parallel_out_oe, .serial_out_early, .serial_out_late);
